// ---- core/cob_config_bank.sv ----
`timescale 1ns/1ps
// Operation
// - pec byte required on writes when set
// - bit 6 enables ratio headroom mode
// - bit 5 linear or non-linear droop
// - bit 3 adaptive ramp, loop compensation
// - bit 2 dynamic bus voltage enable
// - bits 0 and 1 reserved
// - remote temp is slope times adc plus offset
// - bit 4 selects or versus and combining
// - bit 2 enables remote on/off input
// - bit 1 sets remote input polarity
// - bit 0 soft stop or quick off
// - extra compensation threshold halves duty
// - input stable threshold readies new response
// - dac threshold picks one or three lsb
// - sensor select picks internal or remote
module cob_config_bank (
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          scl_i,
   input  wire logic          sda_i,
   output logic               sda_o,
   output logic               sda_oe,
   input  wire logic          rc_pin_i,
   input  wire logic          ctrl_pin_i,
   input  wire logic          operation_on,
   input  wire logic          sensor_select,
   input  wire logic [15:0]   temp_int_raw,
   input  wire logic [15:0]   temp_adc_raw,
   input  wire logic [7:0]    vin_step,
   input  wire logic [7:0]    ref_err,
   output cob_pkg::cob_special_t special_cfg,
   output cob_pkg::cob_remote_t  remote_cfg,
   output cob_pkg::cob_ff_t      ff_cfg,
   output logic               output_on,
   output logic               soft_stop_pulse,
   output logic               quick_off_pulse,
   output logic [15:0]        temp_value,
   output logic               extra_comp_trig,
   output logic               vin_stable,
   output logic [1:0]         dac_step,
   output logic               dac_tick,
   output logic               pec_error
);

   // ==========================================================
   // pin synchronisers
   logic scl_s;
   logic sda_s;
   logic rc_s;
   logic ctrl_s;
   logic scl_q;
   logic sda_q;

   cob_sync #(.WIDTH(4), .RST_VAL(4'hf)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       ({scl_i, sda_i, rc_pin_i, ctrl_pin_i}),
      .q       ({scl_s, sda_s, rc_s, ctrl_s})
   );

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_rise  = scl_s & ~scl_q;
   assign scl_fall  = ~scl_s & scl_q;
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

   // ==========================================================
   // helpers
   function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                            input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ cob_pkg::CRC_POLY) : (r << 1);
      end
      return r;
   endfunction : crc8_step

   function automatic logic [2:0] cmd_len(input logic [7:0] c);
      unique case (c)
         cob_pkg::CMD_SPECIAL_OPT: return cob_pkg::LEN_BYTE;
         cob_pkg::CMD_REMOTE_CFG:  return cob_pkg::LEN_BYTE;
         cob_pkg::CMD_TEMP_OFS:    return cob_pkg::LEN_WORD;
         cob_pkg::CMD_RTEMP_CAL:   return cob_pkg::LEN_BLK;
         cob_pkg::CMD_FF_PARAMS:   return cob_pkg::LEN_BLK;
         default:                  return cob_pkg::LEN_NONE;
      endcase
   endfunction : cmd_len

   // ==========================================================
   // register storage
   logic [15:0] temp_ofs_q;
   cob_pkg::cob_rcal_t rcal_q;

   // ==========================================================
   // bus engine state
   cob_pkg::cob_state_t state_q;
   logic [2:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic       addr_phase_q;
   logic       active_q;
   logic       rw_q;
   logic [7:0] cmd_q;
   logic       cmd_seen_q;
   logic       ack_q;
   logic [2:0] wcnt_q;
   logic [7:0] wbuf_q [5];
   logic [7:0] crc_q;
   logic [7:0] tx_q;
   logic [2:0] ridx_q;

   logic [7:0]  rx_byte;
   logic [2:0]  len;
   logic [31:0] rd_val;
   logic [7:0]  tx_next;

   assign rx_byte = {shift_q[6:0], sda_s};
   assign len     = cmd_len(cmd_q);
   assign sda_o   = 1'b0;

   always_comb begin
      unique case (cmd_q)
         cob_pkg::CMD_SPECIAL_OPT: rd_val = {24'h0, special_cfg};
         cob_pkg::CMD_TEMP_OFS:    rd_val = {16'h0, temp_ofs_q};
         cob_pkg::CMD_RTEMP_CAL:   rd_val = rcal_q;
         cob_pkg::CMD_REMOTE_CFG:  rd_val = {24'h0, remote_cfg};
         cob_pkg::CMD_FF_PARAMS:   rd_val = ff_cfg;
         default:                  rd_val = 32'h0;
      endcase
   end

   // little-endian data, then pec, then idle bytes
   always_comb begin
      if (ridx_q < len) begin
         tx_next = rd_val[{ridx_q[1:0], 3'h0} +: 8];
      end else if (ridx_q == len) begin
         tx_next = crc_q;
      end else begin
         tx_next = cob_pkg::IDLE_BYTE;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q      <= cob_pkg::ST_IDLE;
         bit_cnt_q    <= 3'h0;
         shift_q      <= 8'h00;
         addr_phase_q <= 1'b0;
         active_q     <= 1'b0;
         rw_q         <= 1'b0;
         cmd_q        <= 8'h00;
         cmd_seen_q   <= 1'b0;
         ack_q        <= 1'b0;
         wcnt_q       <= 3'h0;
         crc_q        <= cob_pkg::CRC_INIT;
         tx_q         <= 8'h00;
         ridx_q       <= 3'h0;
         sda_oe       <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            wbuf_q[i] <= 8'h00;
         end
      end else if (stop_det) begin
         state_q  <= cob_pkg::ST_IDLE;
         active_q <= 1'b0;
         sda_oe   <= 1'b0;
      end else if (start_det) begin
         state_q      <= cob_pkg::ST_RX;
         bit_cnt_q    <= 3'h0;
         addr_phase_q <= 1'b1;
         active_q     <= 1'b1;
         sda_oe       <= 1'b0;
         if (!active_q) begin
            crc_q      <= cob_pkg::CRC_INIT;
            cmd_seen_q <= 1'b0;
            wcnt_q     <= 3'h0;
         end
      end else begin
         unique case (state_q)
            cob_pkg::ST_IDLE: begin
               sda_oe <= 1'b0;
            end
            cob_pkg::ST_RX: begin
               if (scl_rise) begin
                  shift_q   <= rx_byte;
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == 3'h7) begin
                     crc_q   <= crc8_step(crc_q, rx_byte);
                     state_q <= cob_pkg::ST_RX_HOLD;
                     if (addr_phase_q) begin
                        ack_q        <= rx_byte[7:1] == cob_pkg::DEV_ADDR;
                        rw_q         <= rx_byte[0];
                        addr_phase_q <= 1'b0;
                        ridx_q       <= 3'h0;
                     end else if (!cmd_seen_q) begin
                        cmd_q      <= rx_byte;
                        cmd_seen_q <= 1'b1;
                        wcnt_q     <= 3'h0;
                        ack_q <= cmd_len(rx_byte) != cob_pkg::LEN_NONE;
                     end else if (wcnt_q < cob_pkg::WBUF_MAX) begin
                        wbuf_q[wcnt_q] <= rx_byte;
                        wcnt_q         <= wcnt_q + 3'h1;
                        ack_q          <= wcnt_q <= len;
                     end else begin
                        ack_q <= 1'b0;
                     end
                  end
               end
            end
            cob_pkg::ST_RX_HOLD: begin
               if (scl_fall) begin
                  sda_oe  <= ack_q;
                  state_q <= ack_q ? cob_pkg::ST_RX_ACK : cob_pkg::ST_IDLE;
               end
            end
            cob_pkg::ST_RX_ACK: begin
               if (scl_fall) begin
                  bit_cnt_q <= 3'h0;
                  if (rw_q) begin
                     tx_q    <= tx_next;
                     sda_oe  <= ~tx_next[7];
                     crc_q   <= crc8_step(crc_q, tx_next);
                     ridx_q  <= ridx_q + 3'h1;
                     state_q <= cob_pkg::ST_TX;
                  end else begin
                     sda_oe  <= 1'b0;
                     state_q <= cob_pkg::ST_RX;
                  end
               end
            end
            cob_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_q == 3'h7) begin
                     sda_oe  <= 1'b0;
                     state_q <= cob_pkg::ST_TX_ACK;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 3'h1;
                     sda_oe    <= ~tx_q[6];
                     tx_q      <= {tx_q[6:0], 1'b0};
                  end
               end
            end
            cob_pkg::ST_TX_ACK: begin
               if (scl_rise) begin
                  state_q <= sda_s ? cob_pkg::ST_IDLE : cob_pkg::ST_TX_LOAD;
               end
            end
            cob_pkg::ST_TX_LOAD: begin
               if (scl_fall) begin
                  bit_cnt_q <= 3'h0;
                  tx_q      <= tx_next;
                  sda_oe    <= ~tx_next[7];
                  crc_q     <= crc8_step(crc_q, tx_next);
                  if (ridx_q < cob_pkg::WBUF_MAX) begin
                     ridx_q <= ridx_q + 3'h1;
                  end
                  state_q <= cob_pkg::ST_TX;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // write commit at stop
   logic        wr_base;
   logic        len_ok;
   logic        pec_ok;
   logic        commit;
   logic [31:0] wdata;

   assign wr_base = stop_det & active_q & cmd_seen_q & ~rw_q &
                    (len != cob_pkg::LEN_NONE);
   assign len_ok  = (wcnt_q == len) & ~special_cfg.pec_required;
   assign pec_ok  = (wcnt_q == 3'(len + 3'h1)) & (crc_q == 8'h00);
   assign commit  = wr_base & (len_ok | pec_ok);
   assign wdata   = {wbuf_q[3], wbuf_q[2], wbuf_q[1], wbuf_q[0]};

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pec_error <= 1'b0;
      end else begin
         pec_error <= wr_base & ~len_ok & ~pec_ok &
                      (wcnt_q >= len);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         special_cfg <= cob_pkg::SPC_RST;
         temp_ofs_q  <= cob_pkg::TOFS_RST;
         rcal_q      <= cob_pkg::RCAL_RST;
         remote_cfg  <= cob_pkg::RC_RST;
         ff_cfg      <= cob_pkg::FF_RST;
      end else if (commit) begin
         unique case (cmd_q)
            cob_pkg::CMD_SPECIAL_OPT:
               special_cfg <= wdata[7:0] & cob_pkg::SPC_WR_MASK;
            cob_pkg::CMD_TEMP_OFS:
               temp_ofs_q <= wdata[15:0];
            cob_pkg::CMD_RTEMP_CAL:
               rcal_q <= wdata;
            cob_pkg::CMD_REMOTE_CFG:
               remote_cfg <= wdata[7:0] & cob_pkg::RC_WR_MASK;
            cob_pkg::CMD_FF_PARAMS:
               ff_cfg <= wdata & cob_pkg::FF_WR_MASK;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // remote on/off combining
   logic rc_asserted;
   logic on_d;

   assign rc_asserted = rc_s ^ remote_cfg.polarity_low;

   always_comb begin
      if (!remote_cfg.input_enable) begin
         on_d = operation_on & ctrl_s;
      end else if (remote_cfg.and_combine) begin
         on_d = operation_on & ctrl_s & rc_asserted;
      end else begin
         on_d = operation_on | ctrl_s | rc_asserted;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         output_on       <= 1'b0;
         soft_stop_pulse <= 1'b0;
         quick_off_pulse <= 1'b0;
      end else begin
         output_on       <= on_d;
         soft_stop_pulse <= output_on & ~on_d &
                            ~remote_cfg.quick_off;
         quick_off_pulse <= output_on & ~on_d &
                            remote_cfg.quick_off;
      end
   end

   // ==========================================================
   // temperature calibration
   logic [31:0] rtemp_prod;

   assign rtemp_prod = rcal_q.slope * temp_adc_raw;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         temp_value <= 16'h0000;
      end else if (sensor_select) begin
         temp_value <= rtemp_prod[15:0] + rcal_q.offset;
      end else begin
         temp_value <= temp_int_raw + temp_ofs_q;
      end
   end

   // ==========================================================
   // voltage feed-forward
   logic [11:0] tick_cnt_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_cnt_q <= 12'h000;
         dac_tick   <= 1'b0;
      end else begin
         dac_tick   <= tick_cnt_q == cob_pkg::TICK_LAST;
         tick_cnt_q <= (tick_cnt_q == cob_pkg::TICK_LAST) ? 12'h000
                                                          : tick_cnt_q + 12'h001;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         extra_comp_trig <= 1'b0;
         vin_stable      <= 1'b0;
         dac_step        <= cob_pkg::DAC_STEP_FINE;
      end else begin
         extra_comp_trig <= ff_cfg.voltage_feed_forward_enable &
                            (vin_step > ff_cfg.extra_comp_thr);
         vin_stable      <= ff_cfg.voltage_feed_forward_enable &
                            (vin_step < ff_cfg.vin_stable_thr);
         dac_step <= (ref_err < ff_cfg.dac_fast_thr) ? cob_pkg::DAC_STEP_FINE
                   : cob_pkg::DAC_STEP_COARSE;
      end
   end

   // special option bits are consumed by the regulation loop:
   // ratio headroom droop shape
   // adaptive ramp bus voltage
   // feed-forward enable gates the extra-comp and vin-stable comparators, not dac_step

endmodule : cob_config_bank

// ---- core/cob_pkg.sv ----
package cob_pkg;

   // ==========================================================
   // command codes
   localparam logic [7:0] CMD_SPECIAL_OPT = 8'he0;
   localparam logic [7:0] CMD_TEMP_OFS    = 8'he1;
   localparam logic [7:0] CMD_RTEMP_CAL   = 8'he2;
   localparam logic [7:0] CMD_REMOTE_CFG  = 8'he3;
   localparam logic [7:0] CMD_FF_PARAMS   = 8'he6;

   // ==========================================================
   // payload lengths in bytes
   localparam logic [2:0] LEN_NONE = 3'h0;
   localparam logic [2:0] LEN_BYTE = 3'h1;
   localparam logic [2:0] LEN_WORD = 3'h2;
   localparam logic [2:0] LEN_BLK  = 3'h4;
   localparam logic [2:0] WBUF_MAX = 3'h5;

   // ==========================================================
   // writable bit masks, reserved bits stay zero
   localparam logic [7:0]  SPC_WR_MASK = 8'hec;
   localparam logic [7:0]  RC_WR_MASK  = 8'h17;
   localparam logic [31:0] FF_WR_MASK  = 32'hffff_ff01;

   // ==========================================================
   // values after reset
   localparam logic [7:0]  SPC_RST  = 8'h00;
   localparam logic [15:0] TOFS_RST = 16'h0000;
   localparam logic [31:0] RCAL_RST = 32'h0000_0000;
   localparam logic [7:0]  RC_RST   = 8'h00;
   localparam logic [31:0] FF_RST   = 32'h0000_0000;

   // ==========================================================
   // bus address and pec
   localparam logic [6:0] DEV_ADDR  = 7'h20;
   localparam logic [7:0] CRC_POLY  = 8'h07;
   localparam logic [7:0] CRC_INIT  = 8'h00;
   localparam logic [7:0] IDLE_BYTE = 8'hff;

   // ==========================================================
   // control interrupt timing and dac steps
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         CTRL_TICK_NS  = 27000;
   localparam int         CTRL_TICK_CYC = CTRL_TICK_NS / CLK_PERIOD_NS;
   localparam logic [11:0] TICK_LAST    = 12'(CTRL_TICK_CYC - 1);
   localparam logic [1:0] DAC_STEP_FINE   = 2'h1;
   localparam logic [1:0] DAC_STEP_COARSE = 2'h3;

   // ==========================================================
   // register layouts
   typedef struct packed {
      logic       pec_required;
      logic       ratio_headroom_enable;
      logic       droop_slope_select;
      logic       rsvd4;
      logic       adaptive_ramp_loop_comp_enable;
      logic       dynamic_bus_voltage_enable;
      logic [1:0] rsvd;
   } cob_special_t;

   typedef struct packed {
      logic [2:0] rsvd;
      logic       and_combine;
      logic       rsvd3;
      logic       input_enable;
      logic       polarity_low;
      logic       quick_off;
   } cob_remote_t;

   typedef struct packed {
      logic [7:0] extra_comp_thr;
      logic [7:0] vin_stable_thr;
      logic [7:0] dac_fast_thr;
      logic [6:0] rsvd;
      logic       voltage_feed_forward_enable;
   } cob_ff_t;

   typedef struct packed {
      logic [15:0] slope;
      logic [15:0] offset;
   } cob_rcal_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_RX_HOLD, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_TX_LOAD
   } cob_state_t;

endpackage : cob_pkg

// ---- core/cob_sync.sv ----
`timescale 1ns/1ps
module cob_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : cob_sync

// ---- test/cob_host.sv ----
`timescale 1ns/1ps
// ==========================================================
// bit-banged bus host, sda released goes high by pull-up
module cob_host (
   input  wire logic sys_clk,
   input  wire logic sda,
   output logic      scl,
   output logic      host_oe
);
   initial begin
      scl = 1'b1;
      host_oe = 1'b0;
   end
   task automatic hp();
      repeat (8) @(posedge sys_clk);
      #1;
   endtask : hp
   task automatic start();
      host_oe = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      host_oe = 1'b1;
      hp();
      scl = 1'b0;
      hp();
   endtask : start
   task automatic stop();
      host_oe = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      host_oe = 1'b0;
      hp();
   endtask : stop
   task automatic bit_x(input logic b, output logic r);
      host_oe = ~b;
      hp();
      scl = 1'b1;
      hp();
      r = sda;
      hp();
      scl = 1'b0;
      hp();
   endtask : bit_x
   // ninth bit: 1 releases sda
   task automatic xfer(input logic [7:0] tx, input logic b9,
                       output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(tx[i], rx[i]);
      bit_x(b9, r);
      ack = ~r;
   endtask : xfer
endmodule : cob_host

// ---- test/cob_config_bank_props.sv ----
`timescale 1ns/1ps
module cob_config_bank_props (
   input wire logic                  sys_clk,
   input wire logic                  rst,
   input wire logic [7:0]            vin_step,
   input wire logic [7:0]            ref_err,
   input wire cob_pkg::cob_special_t special_cfg,
   input wire cob_pkg::cob_remote_t  remote_cfg,
   input wire cob_pkg::cob_ff_t      ff_cfg,
   input wire logic                  output_on,
   input wire logic                  soft_stop_pulse,
   input wire logic                  quick_off_pulse,
   input wire logic                  extra_comp_trig,
   input wire logic                  vin_stable,
   input wire logic [1:0]            dac_step,
   input wire logic                  dac_tick,
   input wire logic                  pec_error
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [11:0] gap_q;
   logic        seen_q;
   // cycles since the last control tick
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gap_q  <= 12'h000;
         seen_q <= 1'b0;
      end else if (dac_tick) begin
         gap_q  <= 12'h000;
         seen_q <= 1'b1;
      end else begin
         gap_q  <= gap_q + 12'h001;
      end
   end
   tick_period_a: assert property (dac_tick && seen_q |-> gap_q == 12'ha8b)
      else $error("control tick spacing wrong");
   tick_late_a: assert property (seen_q |-> gap_q <= 12'ha8b)
      else $error("control tick missing");
   dac_step_a: assert property (1'b1 |=> dac_step ==
      (($past(ref_err) < $past(ff_cfg.dac_fast_thr)) ? 2'h1 : 2'h3))
      else $error("dac step size wrong");
   extra_comp_a: assert property (1'b1 |=> extra_comp_trig ==
      ($past(ff_cfg.voltage_feed_forward_enable)
       && ($past(vin_step) > $past(ff_cfg.extra_comp_thr))))
      else $error("extra compensation trigger wrong");
   vin_stable_a: assert property (1'b1 |=> vin_stable ==
      ($past(ff_cfg.voltage_feed_forward_enable)
       && ($past(vin_step) < $past(ff_cfg.vin_stable_thr))))
      else $error("input stable flag wrong");
   soft_stop_a: assert property ($fell(output_on) && !remote_cfg.quick_off
      |-> ##[0:1] soft_stop_pulse) else $error("soft stop missing");
   quick_off_a: assert property ($fell(output_on) && remote_cfg.quick_off
      |-> ##[0:1] quick_off_pulse) else $error("quick off missing");
   pulse_cause_a: assert property (soft_stop_pulse || quick_off_pulse
      |-> !output_on && !(soft_stop_pulse && quick_off_pulse))
      else $error("stop pulse without turn off");
   rsvd_zero_a: assert property (special_cfg.rsvd == 2'h0
      && !special_cfg.rsvd4 && ff_cfg.rsvd == 7'h00)
      else $error("reserved bits not zero");
   pec_pulse_a: assert property (pec_error |=> !pec_error)
      else $error("pec error longer than one cycle");
endmodule : cob_config_bank_props
bind cob_config_bank cob_config_bank_props u_props (
   .sys_clk(sys_clk), .rst(rst), .vin_step(vin_step), .ref_err(ref_err),
   .special_cfg(special_cfg), .remote_cfg(remote_cfg), .ff_cfg(ff_cfg),
   .output_on(output_on), .soft_stop_pulse(soft_stop_pulse),
   .quick_off_pulse(quick_off_pulse), .extra_comp_trig(extra_comp_trig),
   .vin_stable(vin_stable), .dac_step(dac_step), .dac_tick(dac_tick),
   .pec_error(pec_error)
);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module testbench;
   logic sys_clk, rst, scl_i, host_oe, sda_o, sda_oe, rc_pin_i, ctrl_pin_i;
   logic operation_on, sensor_select, output_on, soft_stop_pulse;
   logic quick_off_pulse, extra_comp_trig, vin_stable, dac_tick, pec_error;
   logic [15:0] temp_int_raw, temp_adc_raw, temp_value;
   logic [7:0]  vin_step, ref_err;
   logic [1:0]  dac_step;
   cob_pkg::cob_special_t special_cfg;
   cob_pkg::cob_remote_t  remote_cfg;
   cob_pkg::cob_ff_t      ff_cfg;
   wire         sda = ~(sda_oe | host_oe);
   int          checks, mismatches, cycles, pec_cnt;
   logic [7:0]  cmds [5] = '{8'he3, 8'he1, 8'he2, 8'he6, 8'he0};
   int          lens [5] = '{1, 2, 4, 4, 1};
   logic [31:0] msks [5] = '{32'h17, 32'hffff, 32'hffffffff,
                             32'hffffff01, 32'hec};
   cob_config_bank dut (.sys_clk(sys_clk), .rst(rst), .scl_i(scl_i),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .rc_pin_i(rc_pin_i),
      .ctrl_pin_i(ctrl_pin_i), .operation_on(operation_on),
      .sensor_select(sensor_select), .temp_int_raw(temp_int_raw),
      .temp_adc_raw(temp_adc_raw), .vin_step(vin_step), .ref_err(ref_err),
      .special_cfg(special_cfg), .remote_cfg(remote_cfg), .ff_cfg(ff_cfg),
      .output_on(output_on), .soft_stop_pulse(soft_stop_pulse),
      .quick_off_pulse(quick_off_pulse), .temp_value(temp_value),
      .extra_comp_trig(extra_comp_trig), .vin_stable(vin_stable),
      .dac_step(dac_step), .dac_tick(dac_tick), .pec_error(pec_error));
   cob_host host (.sys_clk(sys_clk), .sda(sda), .scl(scl_i),
      .host_oe(host_oe));
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (pec_error === 1'b1)
         pec_cnt++;
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         report_and_stop();
      end
   end
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++)
         r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
      return r;
   endfunction : crc8
   // pec: 0 none, 1 correct, 2 corrupted
   task automatic wr(input logic [7:0] cmd, input int n,
                     input logic [31:0] d, input int pec);
      logic [7:0] c, rx;
      logic       a;
      host.start();
      host.xfer(8'h40, 1'b1, rx, a);
      host.xfer(cmd, 1'b1, rx, a);
      c = crc8(crc8(8'h00, 8'h40), cmd);
      for (int i = 0; i < n; i++) begin
         host.xfer(d[8*i+:8], 1'b1, rx, a);
         c = crc8(c, d[8*i+:8]);
      end
      if (pec != 0)
         host.xfer(c ^ 8'(pec - 1), 1'b1, rx, a);
      host.stop();
   endtask : wr
   task automatic rd(input logic [7:0] cmd, input int n,
                     output logic [31:0] d, output logic ca);
      logic [7:0] rx;
      logic       a;
      d = 32'h0;
      host.start();
      host.xfer(8'h40, 1'b1, rx, a);
      host.xfer(cmd, 1'b1, rx, ca);
      if (ca) begin
         host.start();
         host.xfer(8'h41, 1'b1, rx, a);
         for (int i = 0; i < n; i++) begin
            host.xfer(8'hff, 1'b0, rx, a);
            d[8*i+:8] = rx;
         end
         host.xfer(8'hff, 1'b1, rx, a);
      end
      host.stop();
   endtask : rd
   task automatic t_regs();
      logic [31:0] d;
      logic        ca;
      rd(8'he4, 0, d, ca);
      `CHK("unmapped command ack", 1'b0, ca)
      for (int i = 0; i < 5; i++) begin
         rd(cmds[i], lens[i], d, ca);
         `CHK("reset value", 32'h0, d)
         wr(cmds[i], lens[i], 32'hffffffff, 0);
         rd(cmds[i], lens[i], d, ca);
         `CHK("readback", msks[i], d)
      end
      `CHK("special_cfg", 8'hec, special_cfg)
   endtask : t_regs
   task automatic t_pec();
      wr(8'he3, 1, 32'h04, 0);
      `CHK("remote_cfg", 8'h17, remote_cfg)
      `CHK("pec errors", 1, pec_cnt)
      wr(8'he3, 1, 32'h04, 2);
      `CHK("remote_cfg", 8'h17, remote_cfg)
      `CHK("pec errors", 2, pec_cnt)
      wr(8'he3, 1, 32'h04, 1);
      `CHK("remote_cfg", 8'h04, remote_cfg)
      wr(8'he0, 1, 32'h00, 1);
      wr(8'he3, 1, 32'h00, 0);
      `CHK("remote_cfg", 8'h00, remote_cfg)
   endtask : t_pec
   task automatic t_remote();
      logic e;
      for (int c = 0; c < 16; c++) begin
         wr(8'he3, 1, {27'h0, c[3], 1'b0, c[2:0]}, 0);
         for (int k = 0; k < 4; k++) begin
            rc_pin_i = k[1];
            ctrl_pin_i = k[0];
            operation_on = k[0];
            repeat (6) @(posedge sys_clk);
            #1;
            e = c[2] ? (c[3] ? (k[1] ^ c[1]) & k[0] : (k[1] ^ c[1]) | k[0])
                     : k[0];
            `CHK("output_on", e, output_on)
         end
      end
   endtask : t_remote
   task automatic t_temp();
      wr(8'he1, 2, 32'h0123, 0);
      wr(8'he2, 4, 32'h0003_0010, 0);
      temp_int_raw = 16'h1000;
      temp_adc_raw = 16'h0100;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("temp_value", 16'h1123, temp_value)
      sensor_select = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("temp_value", 16'h0310, temp_value)
   endtask : t_temp
   task automatic ff_chk(input logic [7:0] v, input logic [7:0] r,
                         input logic et, input logic es, input logic [1:0] ds);
      vin_step = v;
      ref_err = r;
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("extra_comp_trig", et, extra_comp_trig)
      `CHK("vin_stable", es, vin_stable)
      `CHK("dac_step", ds, dac_step)
   endtask : ff_chk
   task automatic t_ff();
      wr(8'he6, 4, 32'h4010_2001, 0);
      ff_chk(8'h41, 8'h1f, 1'b1, 1'b0, 2'h1);
      ff_chk(8'h40, 8'h20, 1'b0, 1'b0, 2'h3);
      ff_chk(8'h0f, 8'h00, 1'b0, 1'b1, 2'h1);
      ff_chk(8'h10, 8'hff, 1'b0, 1'b0, 2'h3);
      wr(8'he6, 4, 32'h4010_2000, 0);
      ff_chk(8'h41, 8'h1f, 1'b0, 1'b0, 2'h1);
      ff_chk(8'h0f, 8'h20, 1'b0, 1'b0, 2'h3);
   endtask : t_ff
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (checks > 0 && mismatches == 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      {rc_pin_i, ctrl_pin_i, operation_on, sensor_select} = 4'h0;
      {temp_int_raw, temp_adc_raw, vin_step, ref_err} = 48'h0;
      repeat (5) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      t_regs();
      t_pec();
      t_remote();
      t_temp();
      t_ff();
      report_and_stop();
   end
endmodule : testbench
